// ---- rtl/cprot_consts.vh ----
`ifndef CPROT_CONSTS_VH
`define CPROT_CONSTS_VH

// ==========================================================
// Address map (byte addresses of the table address space)
`define CPROT_AW 22
`define CPROT_BOOT_256 22'h000200
`define CPROT_BOOT_512 22'h000400
`define CPROT_BOOT_1K 22'h000800
`define CPROT_BLK1_BIG 22'h001000
`define CPROT_BLK1_SMALL 22'h000800
`define CPROT_PM_END_BIG 22'h002000
`define CPROT_PM_END_SMALL 22'h001000
`define CPROT_UID_BASE 22'h200000
`define CPROT_UID_LAST 22'h200007
`define CPROT_UID_N 8
`define CPROT_DEVID_LO 22'h3FFFFE
`define CPROT_DEVID_HI 22'h3FFFFF

// ==========================================================
// Protection register offsets
`define CPROT_BLOCK_READ_GUARD 22'h300008
`define CPROT_BOOT_EE_READ_GUARD 22'h300009
`define CPROT_BLOCK_WRITE_GUARD 22'h30000A
`define CPROT_SPECIAL_WRITE_GUARD 22'h30000B
`define CPROT_BLOCK_XREAD_GUARD 22'h30000C
`define CPROT_BOOT_XREAD_GUARD 22'h30000D

// ==========================================================
// Field positions
`define CPROT_B_BLK0 0
`define CPROT_B_BLK1 1
`define CPROT_B_EE_CP 7
`define CPROT_B_BOOT_CP 6
`define CPROT_B_EE_WP 7
`define CPROT_B_BOOT_WP 6
`define CPROT_B_CFG_WP 5
`define CPROT_B_BOOT_XR 6

// ==========================================================
// Region codes, boot size codes
`define CPROT_RG_BLK0 2'h0
`define CPROT_RG_BLK1 2'h1
`define CPROT_RG_BOOT 2'h2
`define CPROT_RG_NONE 2'h3
`define CPROT_BBS_256 2'h0
`define CPROT_BBS_512 2'h1

// ==========================================================
// Bit offsets of the bytes inside the 48-bit load image, erased state
`define CPROT_IMG_B1 8
`define CPROT_IMG_B2 16
`define CPROT_IMG_B3 24
`define CPROT_IMG_B4 32
`define CPROT_IMG_B5 40
`define CPROT_ALL_OPEN 3'h7

`endif

// ---- rtl/cprot_unit.v ----
`timescale 1ns/1ps
`include "cprot_consts.vh"
// Summary of operation
// RULE1: Program memory splits into boot, block 0, block 1; rest reads zero.
// RULE2: Boot block size follows the two-bit size field; block 0 follows it.
// RULE3: Each region has code-protect, write-protect and cross-read bits.
// RULE4: Code-protect ignores execution; cleared bit blocks programmer access.
// RULE5: Cleared write-protect bit refuses table writes into that region.
// RULE6: Cleared cross-read bit still allows reads issued from same region.
// RULE7: Cleared cross-read bit returns zero to reads issued from elsewhere.
// RULE8: Table reads and writes reach any program location, checks permitting.
// RULE9: Protection bits only go from 1 to 0 on write.
// RULE10: Only programmer-started chip or block erase sets protection bits.
// RULE11: EEPROM code-protect blocks programmer reads and writes of EEPROM.
// RULE12: EEPROM write-protect rejects all EEPROM writes, CPU or programmer.
// RULE13: CPU reads of EEPROM always permitted.
// RULE14: Configuration write-protect bit is read-only to the CPU.
// RULE15: Configuration write-protect bit guards the configuration bytes.
// RULE16: Device identification word is readable by table reads.
// RULE17: Eight user ID bytes ending at 200007h, readable and writable.
// RULE18: User ID bytes stay readable under code protection.
// RULE19: Block code-protect in bits 1:0; EEPROM and boot in bits 7:6.
// RULE20: Refused table write leaves memory unchanged, no error shown.
module cprot_unit #(
  parameter BIG_PART = 1,
  parameter [15:0] DEVICE_ID = 16'h5A5A // Arbitrary value
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Nonvolatile state load
  input wire load_in,
  input wire [47:0] load_prot_in,
  input wire [1:0] boot_size_select_in,
  // Access request
  input wire req_in,
  input wire src_pgm_in,
  input wire wr_in,
  input wire ee_in,
  input wire erase_in,
  input wire chip_erase_in,
  input wire [`CPROT_AW-1:0] addr_in,
  input wire [`CPROT_AW-1:0] fetch_addr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] mem_rdata_in,
  input wire [7:0] ee_rdata_in,
  // Answer
  output reg ack_out,
  output reg denied_out,
  output reg [7:0] rdata_out,
  // Memory write strobes
  output reg mem_we_out,
  output reg ee_we_out,
  output reg [`CPROT_AW-1:0] mem_addr_out,
  output reg [7:0] mem_wdata_out
);

  // ==========================================================
  // Protection state
  reg [2:0] cp_q;
  reg [2:0] wp_q;
  reg [2:0] xr_q;
  reg ee_cp_q;
  reg ee_wp_q;
  reg cfg_wp_q;
  reg [1:0] boot_sel_q;
  reg [7:0] uid_q [0:`CPROT_UID_N-1];

  // ==========================================================
  // Region limits
  reg [`CPROT_AW-1:0] boot_lim;
  wire [`CPROT_AW-1:0] blk1_base;
  wire [`CPROT_AW-1:0] pm_end;

  // Boot size per part and size code
  always @* begin
    if (boot_sel_q == `CPROT_BBS_256) begin
      boot_lim = `CPROT_BOOT_256; // [RULE2]
    end else if (BIG_PART != 0 && boot_sel_q != `CPROT_BBS_512) begin
      boot_lim = `CPROT_BOOT_1K; // [RULE2]
    end else begin
      boot_lim = `CPROT_BOOT_512; // [RULE2]
    end
  end

  assign blk1_base = (BIG_PART != 0) ? `CPROT_BLK1_BIG : `CPROT_BLK1_SMALL;
  assign pm_end = (BIG_PART != 0) ? `CPROT_PM_END_BIG : `CPROT_PM_END_SMALL;

  // Map an address to its protection region
  function [1:0] region_of;
    input [`CPROT_AW-1:0] a;
    input [`CPROT_AW-1:0] blim;
    input [`CPROT_AW-1:0] b1;
    input [`CPROT_AW-1:0] pend;
    begin
      if (a < blim) begin
        region_of = `CPROT_RG_BOOT; // [RULE1]
      end else if (a < b1) begin
        region_of = `CPROT_RG_BLK0; // [RULE1]
      end else if (a < pend) begin
        region_of = `CPROT_RG_BLK1; // [RULE1]
      end else begin
        region_of = `CPROT_RG_NONE;
      end
    end
  endfunction

  // ==========================================================
  // Request decode
  wire [1:0] tgt_rg;
  wire [1:0] src_rg;
  wire in_pm;
  wire in_uid;
  wire in_cfg;
  wire in_devid;
  wire cp_ok;
  wire wp_ok;
  wire xr_ok;
  wire [2:0] uid_idx;

  assign tgt_rg = region_of(addr_in, boot_lim, blk1_base, pm_end);
  assign src_rg = region_of(fetch_addr_in, boot_lim, blk1_base, pm_end);
  assign in_pm = (tgt_rg != `CPROT_RG_NONE);
  assign in_uid = (addr_in >= `CPROT_UID_BASE) &&
    (addr_in <= `CPROT_UID_LAST);
  assign in_cfg = (addr_in >= `CPROT_BLOCK_READ_GUARD) &&
    (addr_in <= `CPROT_BOOT_XREAD_GUARD);
  assign in_devid = (addr_in >= `CPROT_DEVID_LO);
  assign uid_idx = addr_in[2:0];
  // Per-region checks; index is valid only while in_pm
  assign cp_ok = in_pm && cp_q[tgt_rg]; // [RULE3]
  assign wp_ok = in_pm && wp_q[tgt_rg]; // [RULE3]
  assign xr_ok = in_pm && (xr_q[tgt_rg] || (src_rg == tgt_rg)); // [RULE6]

  // Configuration byte image
  reg [7:0] cfg_rd;
  always @* begin
    cfg_rd = 8'h00;
    if (addr_in == `CPROT_BLOCK_READ_GUARD) begin
      cfg_rd[`CPROT_B_BLK0] = cp_q[`CPROT_RG_BLK0]; // [RULE19]
      cfg_rd[`CPROT_B_BLK1] = cp_q[`CPROT_RG_BLK1]; // [RULE19]
    end else if (addr_in == `CPROT_BOOT_EE_READ_GUARD) begin
      cfg_rd[`CPROT_B_EE_CP] = ee_cp_q; // [RULE19]
      cfg_rd[`CPROT_B_BOOT_CP] = cp_q[`CPROT_RG_BOOT]; // [RULE19]
    end else if (addr_in == `CPROT_BLOCK_WRITE_GUARD) begin
      cfg_rd[`CPROT_B_BLK0] = wp_q[`CPROT_RG_BLK0];
      cfg_rd[`CPROT_B_BLK1] = wp_q[`CPROT_RG_BLK1];
    end else if (addr_in == `CPROT_SPECIAL_WRITE_GUARD) begin
      cfg_rd[`CPROT_B_EE_WP] = ee_wp_q;
      cfg_rd[`CPROT_B_BOOT_WP] = wp_q[`CPROT_RG_BOOT];
      cfg_rd[`CPROT_B_CFG_WP] = cfg_wp_q;
    end else if (addr_in == `CPROT_BLOCK_XREAD_GUARD) begin
      cfg_rd[`CPROT_B_BLK0] = xr_q[`CPROT_RG_BLK0];
      cfg_rd[`CPROT_B_BLK1] = xr_q[`CPROT_RG_BLK1];
    end else if (addr_in == `CPROT_BOOT_XREAD_GUARD) begin
      cfg_rd[`CPROT_B_BOOT_XR] = xr_q[`CPROT_RG_BOOT];
    end
  end

  // Config writes: CPU needs the guard open, programmer always may
  wire cfg_wr;
  wire prog_erase;
  assign cfg_wr = req_in && wr_in && !ee_in && in_cfg &&
    (src_pgm_in || cfg_wp_q); // [RULE15]
  // CPU erase requests are ignored outright
  assign prog_erase = erase_in && src_pgm_in; // [RULE10]

  // ==========================================================
  // Protection bit update; load restores, erase sets, writes clear
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cp_q <= `CPROT_ALL_OPEN;
      wp_q <= `CPROT_ALL_OPEN;
      xr_q <= `CPROT_ALL_OPEN;
      ee_cp_q <= 1'b1;
      ee_wp_q <= 1'b1;
      cfg_wp_q <= 1'b1;
      boot_sel_q <= `CPROT_BBS_256;
    end else if (load_in) begin
      cp_q <= {load_prot_in[`CPROT_IMG_B1 + `CPROT_B_BOOT_CP],
        load_prot_in[`CPROT_B_BLK1], load_prot_in[`CPROT_B_BLK0]};
      ee_cp_q <= load_prot_in[`CPROT_IMG_B1 + `CPROT_B_EE_CP];
      wp_q <= {load_prot_in[`CPROT_IMG_B3 + `CPROT_B_BOOT_WP],
        load_prot_in[`CPROT_IMG_B2 + `CPROT_B_BLK1],
        load_prot_in[`CPROT_IMG_B2 + `CPROT_B_BLK0]};
      ee_wp_q <= load_prot_in[`CPROT_IMG_B3 + `CPROT_B_EE_WP];
      cfg_wp_q <= load_prot_in[`CPROT_IMG_B3 + `CPROT_B_CFG_WP];
      xr_q <= {load_prot_in[`CPROT_IMG_B5 + `CPROT_B_BOOT_XR],
        load_prot_in[`CPROT_IMG_B4 + `CPROT_B_BLK1],
        load_prot_in[`CPROT_IMG_B4 + `CPROT_B_BLK0]};
      boot_sel_q <= boot_size_select_in;
    end else if (prog_erase && chip_erase_in) begin
      cp_q <= `CPROT_ALL_OPEN; // [RULE10]
      wp_q <= `CPROT_ALL_OPEN;
      xr_q <= `CPROT_ALL_OPEN;
      ee_cp_q <= 1'b1;
      ee_wp_q <= 1'b1;
      cfg_wp_q <= 1'b1;
    end else if (prog_erase) begin
      // Block erase restores only the addressed region
      if (in_pm) begin
        cp_q[tgt_rg] <= 1'b1; // [RULE10]
        wp_q[tgt_rg] <= 1'b1;
        xr_q[tgt_rg] <= 1'b1;
      end
    end else if (cfg_wr) begin
      // AND with old value: a 1 never revives a cleared bit
      if (addr_in == `CPROT_BLOCK_READ_GUARD) begin
        cp_q[1:0] <= cp_q[1:0] & wdata_in[1:0]; // [RULE9]
      end else if (addr_in == `CPROT_BOOT_EE_READ_GUARD) begin
        ee_cp_q <= ee_cp_q & wdata_in[`CPROT_B_EE_CP]; // [RULE9]
        cp_q[`CPROT_RG_BOOT] <= cp_q[`CPROT_RG_BOOT] &
          wdata_in[`CPROT_B_BOOT_CP];
      end else if (addr_in == `CPROT_BLOCK_WRITE_GUARD) begin
        wp_q[1:0] <= wp_q[1:0] & wdata_in[1:0]; // [RULE9]
      end else if (addr_in == `CPROT_SPECIAL_WRITE_GUARD) begin
        ee_wp_q <= ee_wp_q & wdata_in[`CPROT_B_EE_WP];
        wp_q[`CPROT_RG_BOOT] <= wp_q[`CPROT_RG_BOOT] &
          wdata_in[`CPROT_B_BOOT_WP];
        if (src_pgm_in) begin
          cfg_wp_q <= cfg_wp_q & wdata_in[`CPROT_B_CFG_WP]; // [RULE14]
        end
      end else if (addr_in == `CPROT_BLOCK_XREAD_GUARD) begin
        xr_q[1:0] <= xr_q[1:0] & wdata_in[1:0]; // [RULE9]
      end else begin
        xr_q[`CPROT_RG_BOOT] <= xr_q[`CPROT_RG_BOOT] &
          wdata_in[`CPROT_B_BOOT_XR];
      end
    end
  end

  // ==========================================================
  // User ID bytes: no reset, plain storage, always accessible
  genvar gi;
  generate
    for (gi = 0; gi < `CPROT_UID_N; gi = gi + 1) begin : g_uid
      always @(posedge mclk_in) begin
        if (req_in && wr_in && !ee_in && in_uid && uid_idx == gi) begin
          uid_q[gi] <= wdata_in; // [RULE17]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Answer path: one registered reply per request
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      denied_out <= 1'b0;
      rdata_out <= 8'h00;
      mem_we_out <= 1'b0;
      ee_we_out <= 1'b0;
      mem_addr_out <= {`CPROT_AW{1'b0}};
      mem_wdata_out <= 8'h00;
    end else begin
      ack_out <= req_in;
      denied_out <= 1'b0;
      rdata_out <= 8'h00;
      mem_we_out <= 1'b0;
      ee_we_out <= 1'b0;
      if (req_in) begin
        mem_addr_out <= addr_in;
        mem_wdata_out <= wdata_in;
      end
      if (req_in && ee_in) begin
        if (src_pgm_in && !ee_cp_q) begin
          denied_out <= 1'b1; // [RULE11]
        end else if (wr_in) begin
          ee_we_out <= ee_wp_q; // [RULE12]
          denied_out <= src_pgm_in && !ee_wp_q;
        end else begin
          rdata_out <= ee_rdata_in; // [RULE13]
        end
      end else if (req_in && in_pm && src_pgm_in) begin
        // Programmer path: only code-protect matters
        if (!cp_ok) begin
          denied_out <= 1'b1; // [RULE4]
        end else if (wr_in) begin
          mem_we_out <= 1'b1;
        end else begin
          rdata_out <= mem_rdata_in;
        end
      end else if (req_in && in_pm) begin
        // CPU path: refusals are silent
        if (wr_in) begin
          mem_we_out <= wp_ok; // [RULE5] [RULE8] [RULE20]
        end else if (xr_ok) begin
          rdata_out <= mem_rdata_in; // [RULE6] [RULE8]
        end else begin
          rdata_out <= 8'h00; // [RULE7]
        end
      end else if (req_in && !wr_in && in_uid) begin
        rdata_out <= uid_q[uid_idx]; // [RULE18]
      end else if (req_in && !wr_in && in_cfg) begin
        rdata_out <= cfg_rd;
      end else if (req_in && !wr_in && in_devid) begin
        rdata_out <= addr_in[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0]; // [RULE16]
      end else if (req_in && wr_in && in_cfg && !cfg_wr) begin
        denied_out <= src_pgm_in;
      end
    end
  end

endmodule // cprot_unit

// ---- testbench/cprot_unit_props.sv ----
`timescale 1ns/1ps
// ==========================================
// Port checker for the protection unit
module cprot_unit_props (
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Request side
  input wire req_in,
  input wire src_pgm_in,
  input wire wr_in,
  input wire ee_in,
  input wire [21:0] addr_in,
  input wire [7:0] ee_rdata_in,
  // Answer side
  input wire ack_out,
  input wire denied_out,
  input wire [7:0] rdata_out,
  input wire mem_we_out,
  input wire ee_we_out,
  input wire [21:0] mem_addr_out
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_ACK_FOLLOWS: assert property (req_in |=> ack_out)
    else $error("ack missing after request");
  AST_NO_SPURIOUS: assert property (!req_in |=>
    !ack_out && !mem_we_out && !ee_we_out)
    else $error("strobe without request");
  AST_CPU_NEVER_DENIED: assert property (req_in && !src_pgm_in |=>
    !denied_out) else $error("cpu access flagged");
  AST_DENY_CLEAN: assert property (denied_out |-> rdata_out == 8'h00
    && !mem_we_out && !ee_we_out) else $error("denied access leaked");
  AST_IDLE_RDATA: assert property (!ack_out |-> rdata_out == 8'h00)
    else $error("read data outside answer");
  AST_UNIMPL_ZERO: assert property (req_in && !wr_in && !ee_in
    && addr_in >= 22'h002000 && addr_in < 22'h200000 |=> rdata_out == 8'h00)
    else $error("unimplemented read not zero");
  AST_EE_CPU_READ: assert property (req_in && !src_pgm_in && !wr_in
    && ee_in |=> rdata_out == $past(ee_rdata_in)) else $error("ee read lost");
  AST_EE_WE_CAUSE: assert property (ee_we_out |->
    $past(req_in && wr_in && ee_in)) else $error("ee strobe without write");
  AST_ADDR_COPY: assert property (req_in |=>
    mem_addr_out == $past(addr_in)) else $error("address copy wrong");
endmodule // cprot_unit_props

bind cprot_unit cprot_unit_props u_props (.mclk_in(mclk_in),
  .rst_b_in(rst_b_in), .req_in(req_in), .src_pgm_in(src_pgm_in),
  .wr_in(wr_in), .ee_in(ee_in), .addr_in(addr_in),
  .ee_rdata_in(ee_rdata_in), .ack_out(ack_out), .denied_out(denied_out),
  .rdata_out(rdata_out), .mem_we_out(mem_we_out), .ee_we_out(ee_we_out),
  .mem_addr_out(mem_addr_out));

// ---- testbench/cprot_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Flash and EEPROM arrays behind the unit
module cprot_mem_model (
  // Address
  input wire [21:0] addr_in,
  // Combinational read data
  output wire [7:0] mem_rdata_out,
  output wire [7:0] ee_rdata_out
);
  // Address-derived patterns, never zero at once, so a zeroed read shows
  assign mem_rdata_out = addr_in[7:0] ^ 8'h5C;
  assign ee_rdata_out = addr_in[7:0] ^ 8'hC3;
endmodule // cprot_mem_model

// ---- testbench/cprot_unit_test.sv ----
`timescale 1ns/1ps
// ==========================================
// Bench for the protection unit
module cprot_unit_test;
  logic mclk_in = 0, rst_b_in = 0, load_in = 0, req_in = 0, src_pgm_in = 0;
  logic wr_in = 0, ee_in = 0, erase_in = 0, chip_erase_in = 0;
  logic [47:0] load_prot_in = 0;
  logic [1:0] boot_size_select_in = 0;
  logic [21:0] addr_in = 0, fetch_addr_in = 0, b;
  logic [7:0] wdata_in = 0, rd;
  wire [7:0] mem_rdata_in, ee_rdata_in, rdata_out, mem_wdata_out;
  wire [21:0] mem_addr_out;
  wire ack_out, denied_out, mem_we_out, ee_we_out;
  logic dn, mwe, ewe;
  int failures = 0, checks_done = 0;
  // Identification value is arbitrary
  cprot_unit #(.BIG_PART(1), .DEVICE_ID(16'hC31E)) u_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .load_in(load_in),
    .load_prot_in(load_prot_in), .boot_size_select_in(boot_size_select_in),
    .req_in(req_in), .src_pgm_in(src_pgm_in), .wr_in(wr_in), .ee_in(ee_in),
    .erase_in(erase_in), .chip_erase_in(chip_erase_in), .addr_in(addr_in),
    .fetch_addr_in(fetch_addr_in), .wdata_in(wdata_in),
    .mem_rdata_in(mem_rdata_in), .ee_rdata_in(ee_rdata_in),
    .ack_out(ack_out), .denied_out(denied_out), .rdata_out(rdata_out),
    .mem_we_out(mem_we_out), .ee_we_out(ee_we_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out));
  cprot_mem_model u_mem (.addr_in(addr_in), .mem_rdata_out(mem_rdata_in),
    .ee_rdata_out(ee_rdata_in));
  // Clock
  always #2.5 mclk_in = ~mclk_in;
  function automatic logic [7:0] md(input logic [21:0] a);
    return a[7:0] ^ 8'h5C;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // One request, answer captured one edge later
  task automatic acc(input logic p, w, e, input logic [21:0] a, f,
                     input logic [7:0] d);
    {src_pgm_in, wr_in, ee_in, addr_in, fetch_addr_in, wdata_in} =
      {p, w, e, a, f, d};
    req_in = 1;
    @(posedge mclk_in);
    #1 req_in = 0;
    {rd, dn, mwe, ewe} = {rdata_out, denied_out, mem_we_out, ee_we_out};
    @(posedge mclk_in);
    #1;
  endtask
  task automatic ld(input logic [47:0] img, input logic [1:0] bs);
    {load_prot_in, boot_size_select_in, load_in} = {img, bs, 1'b1};
    @(posedge mclk_in);
    #1 load_in = 0;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic ers(input logic p, c, input logic [21:0] a);
    {src_pgm_in, chip_erase_in, addr_in, erase_in} = {p, c, a, 1'b1};
    @(posedge mclk_in);
    #1 erase_in = 0;
    @(posedge mclk_in);
    #1;
  endtask
  // Boot size codes and cross-block reads
  task automatic s_regions;
    for (int i = 0; i < 4; i++) begin
      ld(48'hFFFE_FFFF_FFFF, i[1:0]);
      b = (i == 0) ? 22'h200 : (i == 1) ? 22'h400 : 22'h800;
      acc(0, 0, 0, b, 0, 0);
      chk("xread_out", rd, 0);
      acc(0, 0, 0, b - 1, 0, 0);
      chk("boot_read", rd, md(b - 1));
      acc(0, 0, 0, b, b + 2, 0);
      chk("xread_in", rd, md(b));
    end
    acc(0, 0, 0, 22'h1000, 0, 0);
    chk("blk1_read", rd, md(22'h1000));
    acc(0, 0, 0, 22'h2000, 0, 0);
    chk("unimpl", rd, 0);
  endtask
  // Write guards and config byte writes
  task automatic s_write;
    ld(48'hFFFF_FFFE_FFFF, 3);
    acc(0, 1, 0, 22'h800, 0, 8'h11);
    chk("wp_we", {dn, mwe}, 0);
    acc(0, 1, 0, 22'h1000, 0, 8'h22);
    chk("open_we", {mwe, mem_wdata_out}, 9'h122);
    acc(0, 1, 0, 22'h30000A, 0, 8'hFF);
    acc(0, 1, 0, 22'h800, 0, 8'h11);
    chk("no_set", mwe, 0);
    acc(0, 1, 0, 22'h30000B, 0, 8'hDF);
    acc(0, 1, 0, 22'h30000A, 0, 8'hFC);
    acc(0, 1, 0, 22'h1000, 0, 8'h22);
    chk("cfg_wp_kept", mwe, 0);
    acc(1, 1, 0, 22'h30000B, 0, 8'hDF); // Programmer clears it
    acc(0, 1, 0, 22'h30000B, 0, 8'hBF);
    acc(0, 1, 0, 22'h0, 0, 8'h33);
    chk("cfg_locked", mwe, 1);
  endtask
  // Programmer refusals, EEPROM guards, erases
  task automatic s_pgm;
    ld(48'hFFFF_7FFF_7FFD, 3);
    acc(0, 0, 0, 22'h300008, 0, 0);
    chk("cfg_rd_cp", rd, 8'h01);
    acc(0, 0, 0, 22'h300009, 0, 0);
    chk("cfg_rd_ee", rd, 8'h40);
    acc(1, 0, 0, 22'h1000, 0, 0);
    chk("cp_deny", {dn, rd}, 9'h100);
    acc(0, 0, 0, 22'h1000, 22'h1004, 0);
    chk("cp_cpu", rd, md(22'h1000));
    acc(1, 0, 1, 22'h10, 0, 0);
    chk("ee_cp", dn, 1);
    acc(0, 0, 1, 22'h10, 0, 0);
    chk("ee_cpu_rd", rd, 8'hD3);
    acc(0, 1, 1, 22'h10, 0, 8'h44);
    chk("ee_wp", ewe, 0);
    ers(0, 0, 22'h1000); // CPU-started erase must be ignored
    acc(1, 0, 0, 22'h1000, 0, 0);
    chk("cpu_erase", dn, 1);
    ers(1, 0, 22'h1000);
    acc(1, 0, 0, 22'h1000, 0, 0);
    chk("blk_erase", {dn, rd}, {1'b0, md(22'h1000)});
    ers(1, 1, 22'h0);
    acc(1, 1, 1, 22'h10, 0, 8'h55);
    chk("chip_erase", ewe, 1);
  endtask
  // Device and user identification under full protection
  task automatic s_ids;
    ld(48'h0, 3);
    acc(0, 0, 0, 22'h3FFFFE, 22'h1000, 0);
    chk("devid_lo", rd, 8'h1E);
    acc(0, 0, 0, 22'h3FFFFF, 22'h1000, 0);
    chk("devid_hi", rd, 8'hC3);
    acc(0, 1, 0, 22'h200007, 22'h1000, 8'h66);
    chk("uid_wr", {dn, mwe}, 0);
    acc(0, 1, 0, 22'h200000, 22'h1000, 8'h77);
    acc(0, 0, 0, 22'h200000, 22'h1000, 0);
    chk("uid_rd", rd, 8'h77);
    acc(1, 0, 0, 22'h200007, 0, 0);
    chk("uid_pgm", {dn, rd}, 9'h066);
  endtask
  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence, reset held four cycles
  initial begin
    repeat (4) @(posedge mclk_in);
    #1 rst_b_in = 1;
    s_regions;
    s_write;
    s_pgm;
    s_ids;
    conclude;
  end
  // Watchdog, far beyond the roughly one hundred cycles needed
  initial begin
    #20000;
    failures++;
    conclude;
  end
endmodule // cprot_unit_test
